// File: verilog/link_startup_control.v
// Purpose: link start-up sequencing of a single-pair ethernet phy
// Assumes: one clock at 125 MHz, synchronous active-high reset
// Notes: register port is the word level of the management interface
//
// Overview of operation
// - no link attempt in either role before link enable is one.
// - master starts training by sending idle once link enabled.
// - slave trains and sends idle only after receiver synchronised to master.
// - slave training moves to idle-only transmit at minimum timer expiry.
// - master enters idle-or-data when local and remote receivers both ok.
// - slave enters idle-or-data when master receiver status reads ok.
// - autonomous operation sets link enable itself after the post-normal timeout.
// - four link flags readable; host waits for all before communicating.
// - link-good event pulses when the link good flag becomes set.
// - training-failure event when maximum timer expires before link.
// - after training failure the start-up restarts without host help.
// - slave corrects inverted polarity, continues, and flags the inversion.
// - role affects start-up only; data phase identical for both roles.
`include "link_startup_regs.vh"
module link_startup_control #(
    parameter [25:0] NORMAL_WAIT_CYCLES = `NORMAL_WAIT_CYC,
    parameter [25:0] MINWAIT_CYCLES = `MINWAIT_CYC,
    parameter [25:0] MAXWAIT_CYCLES = `MAXWAIT_CYC
) (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // power mode
    input wire normal_mode_in,
    // register port
    input wire reg_write_in,
    input wire reg_read_in,
    input wire [4:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    output reg [15:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // line receiver status, from the pma/pcs
    input wire rx_synced_in,
    input wire rem_rcvr_ok_in,
    input wire loc_rcvr_ok_in,
    input wire descrambler_lock_flag_in,
    input wire polarity_inverted_in,
    // line control
    output reg [1:0] tx_mode_out,
    output reg polarity_swap_out,
    output reg data_enable_out,
    // events
    output reg link_good_event_out,
    output reg training_timeout_event_out
);
    ////////////////////////////////////////////////////////////////////
    localparam [1:0] TX_SEND_Z = 2'h0;
    localparam [1:0] TX_SEND_I = 2'h1;
    localparam [1:0] TX_SEND_N = 2'h2;
    localparam [2:0] ST_DISABLED = 3'h0;
    localparam [2:0] ST_WAIT_SYNC = 3'h1;
    localparam [2:0] ST_TRAINING = 3'h2;
    localparam [2:0] ST_SEND_IDLE = 3'h3;
    localparam [2:0] ST_IDLE_OR_DATA = 3'h4;
    localparam LINE_SYNCED = 0;
    localparam LINE_REM_OK = 1;
    localparam LINE_LOC_OK = 2;
    localparam LINE_LOCK = 3;
    localparam LINE_POL_INV = 4;
    localparam LINE_INPUTS = 5;

    wire [LINE_INPUTS-1:0] line_raw;
    wire [LINE_INPUTS-1:0] line_sync;
    wire rx_synced;
    wire rem_ok;
    wire loc_ok;
    wire lock_ok;
    wire pol_inv;
    reg [15:0] control;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [25:0] train_timer;
    reg [25:0] min_timer;
    reg [25:0] normal_timer;
    reg normal_done;
    reg link_good;
    reg polarity_found;
    wire link_enable;
    wire autonomous;
    wire master;
    wire min_expired;
    wire max_expired;

    function [15:0] status_word;
        input lr;
        input rr;
        input dl;
        input lg;
        input pf;
        input [2:0] st;
        begin
            status_word = 16'h0000;
            status_word[`STA_LOC_RCVR_BIT] = lr;
            status_word[`STA_REM_RCVR_BIT] = rr;
            status_word[`STA_DESCRAMBLER_LOCK_BIT] = dl;
            status_word[`STA_LINK_GOOD_BIT] = lg;
            status_word[`STA_POLARITY_BIT] = pf;
            status_word[`STA_TRAINING_STATE_MSB:`STA_TRAINING_STATE_LSB] = st;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // start-up states are the ones guarded by the maximum training timer
    function in_startup;
        input [2:0] st;
        begin
            in_startup = (st == ST_WAIT_SYNC) || (st == ST_TRAINING) || (st == ST_SEND_IDLE);
        end
    endfunction

    // line pattern for each state; the line stays silent until training starts
    function [1:0] line_mode;
        input [2:0] st;
        begin
            case (st)
                ST_TRAINING: line_mode = TX_SEND_I;
                ST_SEND_IDLE: line_mode = TX_SEND_I;
                ST_IDLE_OR_DATA: line_mode = TX_SEND_N;
                default: line_mode = TX_SEND_Z;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // line status comes from the analog front end clocking, so synchronise
    assign line_raw = {
        polarity_inverted_in,
        descrambler_lock_flag_in,
        loc_rcvr_ok_in,
        rem_rcvr_ok_in,
        rx_synced_in
    };
    genvar gi;
    generate
        for (gi = 0; gi < LINE_INPUTS; gi = gi + 1) begin : g_line_sync
            sync3 u_sync (
                .clk_sys_in(clk_sys_in),
                .reset_in(reset_in),
                .async_in(line_raw[gi]),
                .level_out(line_sync[gi])
            );
        end
    endgenerate
    assign rx_synced = line_sync[LINE_SYNCED];
    assign rem_ok = line_sync[LINE_REM_OK];
    assign loc_ok = line_sync[LINE_LOC_OK];
    assign lock_ok = line_sync[LINE_LOCK];
    assign pol_inv = line_sync[LINE_POL_INV];

    assign link_enable = control[`CTL_LINK_ENABLE_BIT];
    assign autonomous = control[`CTL_AUTONOMOUS_OPERATION_BIT];
    assign master = control[`CTL_MASTER_ROLE_BIT];
    assign min_expired = (min_timer >= MINWAIT_CYCLES);
    assign max_expired = (train_timer >= MAXWAIT_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // post-normal-mode timer; restarts whenever normal mode drops
    // it stops at its end value so a long stay in normal mode cannot wrap it
    always @(posedge clk_sys_in) begin
        if (reset_in || !normal_mode_in) begin
            normal_timer <= 26'h0000000;
            normal_done <= 1'b0;
        end else if (normal_timer >= NORMAL_WAIT_CYCLES) begin
            normal_done <= 1'b1;
        end else begin
            normal_timer <= normal_timer + 26'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register; autonomous enable waits for the normal-mode timeout
    // the autonomous set comes last, so it wins over a same-cycle host write
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            control <= `CTL_RESET_VALUE;
        end else begin
            if (reg_write_in && reg_addr_in == `REG_LINK_AND_POWER_CONTROL) begin
                control <= reg_wdata_in;
            end
            if (autonomous && normal_done && !link_enable) begin
                control[`CTL_LINK_ENABLE_BIT] <= 1'b1;
            end
        end
    end

    // read port answers one cycle later; unmapped addresses read zero
    // status uses filtered levels, so a read never sees a flag mid-change
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_read_in;
            if (reg_read_in) begin
                case (reg_addr_in)
                    `REG_LINK_AND_POWER_CONTROL: reg_rdata_out <= control;
                    `REG_LINK_STATE_FLAGS: reg_rdata_out <= status_word(loc_ok, rem_ok, lock_ok,
                        link_good, polarity_found, state);
                    default: reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always @* begin
        next_state = state;
        case (state)
            ST_DISABLED: begin
                if (link_enable) begin
                    next_state = master ? ST_TRAINING : ST_WAIT_SYNC;
                end
            end
            ST_WAIT_SYNC: begin
                if (rx_synced) begin
                    next_state = ST_TRAINING;
                end
            end
            ST_TRAINING: begin
                if (!master && min_expired) begin
                    next_state = ST_SEND_IDLE;
                end else if (master && loc_ok && rem_ok) begin
                    next_state = ST_IDLE_OR_DATA;
                end
            end
            ST_SEND_IDLE: begin
                if (rem_ok) begin
                    next_state = ST_IDLE_OR_DATA;
                end
            end
            ST_IDLE_OR_DATA: begin
                if (!loc_ok) begin
                    next_state = ST_DISABLED;
                end
            end
            default: next_state = ST_DISABLED;
        endcase
        if (!link_enable) begin
            next_state = ST_DISABLED;
        end else if (in_startup(state) && max_expired) begin
            next_state = ST_DISABLED;
        end
    end

    // timer counts from the moment link enable leaves the disabled state
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            state <= ST_DISABLED;
            train_timer <= 26'h0000000;
            training_timeout_event_out <= 1'b0;
        end else begin
            state <= next_state;
            training_timeout_event_out <= link_enable && max_expired && in_startup(state);
            if (!in_startup(next_state)) begin
                train_timer <= 26'h0000000;
            end else if (!max_expired) begin
                train_timer <= train_timer + 26'h0000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // minimum training time runs in training only, so a slow sync cannot shorten it
    always @(posedge clk_sys_in) begin
        if (reset_in || next_state != ST_TRAINING) begin
            min_timer <= 26'h0000000;
        end else if (!min_expired) begin
            min_timer <= min_timer + 26'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit mode and data path; role matters only before idle-or-data
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            tx_mode_out <= TX_SEND_Z;
            data_enable_out <= 1'b0;
            link_good <= 1'b0;
            link_good_event_out <= 1'b0;
            polarity_swap_out <= 1'b0;
            polarity_found <= 1'b0;
        end else begin
            tx_mode_out <= line_mode(next_state);
            data_enable_out <= (next_state == ST_IDLE_OR_DATA);
            link_good <= (next_state == ST_IDLE_OR_DATA) && lock_ok;
            link_good_event_out <= (next_state == ST_IDLE_OR_DATA) && lock_ok && !link_good;
            // slave corrects polarity while acquiring; held through the link
            if (state == ST_DISABLED) begin
                polarity_swap_out <= 1'b0;
                polarity_found <= 1'b0;
            end else if (!master && state == ST_WAIT_SYNC && pol_inv) begin
                polarity_swap_out <= 1'b1;
                polarity_found <= 1'b1;
            end
        end
    end
endmodule // link_startup_control

// File: verilog/link_startup_regs.vh
// Purpose: constants for the link start-up controller
// Assumes: 125 MHz clock, 8 ns period
// Notes: register offsets are management register addresses
`ifndef LINK_STARTUP_REGS_VH
`define LINK_STARTUP_REGS_VH
`define REG_LINK_AND_POWER_CONTROL 5'h11
`define REG_LINK_STATE_FLAGS 5'h17
// link_and_power_control fields
`define CTL_LINK_ENABLE_BIT 15
`define CTL_AUTONOMOUS_OPERATION_BIT 3
`define CTL_MASTER_ROLE_BIT 2
`define CTL_RESET_VALUE 16'h0000
// link_state_flags fields
`define STA_LOC_RCVR_BIT 15
`define STA_REM_RCVR_BIT 14
`define STA_DESCRAMBLER_LOCK_BIT 13
`define STA_LINK_GOOD_BIT 12
`define STA_POLARITY_BIT 11
`define STA_TRAINING_STATE_MSB 10
`define STA_TRAINING_STATE_LSB 8
// times and clock; cycle counts are 2 ms, 1 ms and 200 ms at 8 ns
`define CLK_PERIOD_NS 8
`define NORMAL_WAIT_CYC 26'h3d090
`define MINWAIT_CYC 26'h1e848
`define MAXWAIT_CYC 26'h17d7840
`define TIMER_WIDTH 26
`endif

// File: verilog/sync3.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes: output changes only when stages two and three agree
module sync3 (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // level
    input wire async_in,
    output reg level_out
);
    reg stage1;
    reg stage2;
    reg stage3;
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end
endmodule // sync3

// File: bench/link_startup_checker.sv
// Purpose: assertions on the link start-up controller ports
// Assumes: single clock, synchronous active-high reset
// Notes: enable and role are tracked from control writes
module link_startup_checker (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // register port
    input wire reg_write_in,
    input wire reg_read_in,
    input wire [4:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_rvalid_out,
    // line side
    input wire rx_synced_in,
    input wire [1:0] tx_mode_out,
    input wire data_enable_out,
    input wire link_good_event_out,
    input wire training_timeout_event_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////
    // autonomous bit counts as enable: the device may set it alone
    logic en_seen;
    logic is_master;
    wire ctl_wr = reg_write_in && reg_addr_in == 5'h11;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            en_seen <= 1'b0;
            is_master <= 1'b0;
        end else if (ctl_wr) begin
            en_seen <= reg_wdata_in[15] | reg_wdata_in[3];
            is_master <= reg_wdata_in[2];
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_rvalid; reg_read_in |=> reg_rvalid_out; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    property p_quiet; !en_seen |-> tx_mode_out == 2'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("link attempt while disabled");
    property p_mstart; ctl_wr && reg_wdata_in[15] && reg_wdata_in[2] && !en_seen |-> ##[1:3] tx_mode_out == 2'h1;
    endproperty
    a_mstart: assert property (p_mstart) else $error("master did not start training");
    property p_sstart; $rose(tx_mode_out == 2'h1) && !is_master |-> $past(rx_synced_in); endproperty
    a_sstart: assert property (p_sstart) else $error("slave trained before sync");
    property p_order; tx_mode_out == 2'h2 |-> $past(tx_mode_out) != 2'h0; endproperty
    a_order: assert property (p_order) else $error("data mode without training");
    property p_data; data_enable_out |-> tx_mode_out == 2'h2; endproperty
    a_data: assert property (p_data) else $error("data enabled outside data mode");
    property p_good; link_good_event_out |-> tx_mode_out == 2'h2 ##1 !link_good_event_out; endproperty
    a_good: assert property (p_good) else $error("bad link good event");
    property p_tmo; training_timeout_event_out |-> !data_enable_out ##1 !training_timeout_event_out; endproperty
    a_tmo: assert property (p_tmo) else $error("bad training timeout event");
    c_good: cover property (link_good_event_out);
    c_tmo: cover property (training_timeout_event_out);
    c_slave: cover property (tx_mode_out == 2'h2 && !is_master);
endmodule // link_startup_checker
bind link_startup_control link_startup_checker link_startup_checker_i (.clk_sys_in, .reset_in, .reg_write_in,
    .reg_read_in, .reg_addr_in, .reg_wdata_in, .reg_rvalid_out, .rx_synced_in, .tx_mode_out, .data_enable_out,
    .link_good_event_out, .training_timeout_event_out);

// File: bench/remote_phy_model.sv
// Purpose: remote phy on the pair, seen as receiver status levels
// Assumes: the device's tx_mode stands for what it puts on the line
// Notes: slow_in models a late partner, alive_in low a dead line
module remote_phy_model (
    input wire clk_sys_in,
    input wire alive_in,
    input wire slow_in,
    input wire invert_in,
    input wire [1:0] tx_mode_in,
    output logic rx_synced_out,
    output logic rem_ok_out,
    output logic loc_ok_out,
    output logic lock_out,
    output logic pol_inv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // lock needs the device to keep sending idle
    always @(posedge clk_sys_in) cnt <= (alive_in && tx_mode_in != 2'h0) ? cnt + 1 : 0;
    assign rx_synced_out = alive_in; // far side sends idle
    assign loc_ok_out = cnt > (slow_in ? 120 : 10);
    assign rem_ok_out = cnt > (slow_in ? 130 : 16);
    assign lock_out = loc_ok_out;
    assign pol_inv_out = alive_in & invert_in;
endmodule // remote_phy_model

// File: bench/t1_link_startup_control_tb.sv
// Purpose: self-checking bench of the link start-up controller
// Assumes: reads are checked from a queue when the answer shows
// Notes: timers shortened to 20/50/200 cycles
module t1_link_startup_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 0, reset_in = 1, normal_mode_in = 1, reg_write_in = 0, reg_read_in = 0;
    logic [4:0] reg_addr_in = 0;
    logic [15:0] reg_wdata_in = 0, exp_q[$];
    logic alive = 0, slow = 0, invert = 0, rx_synced_in, rem_rcvr_ok_in, loc_rcvr_ok_in;
    logic descrambler_lock_flag_in, polarity_inverted_in, reg_rvalid_out, polarity_swap_out;
    logic data_enable_out, link_good_event_out, training_timeout_event_out;
    logic [15:0] reg_rdata_out;
    logic [1:0] tx_mode_out;
    string name_q[$];
    int n_errors = 0, total_checks = 0, n_good = 0, n_tmo = 0;
    link_startup_control #(.NORMAL_WAIT_CYCLES(20), .MINWAIT_CYCLES(50), .MAXWAIT_CYCLES(200))
        link_startup_control_i (.clk_sys_in, .reset_in, .normal_mode_in, .reg_write_in, .reg_read_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .rx_synced_in, .rem_rcvr_ok_in,
        .loc_rcvr_ok_in, .descrambler_lock_flag_in, .polarity_inverted_in, .tx_mode_out, .polarity_swap_out,
        .data_enable_out, .link_good_event_out, .training_timeout_event_out);
    remote_phy_model remote_phy_model_i (.clk_sys_in, .alive_in(alive), .slow_in(slow), .invert_in(invert),
        .tx_mode_in(tx_mode_out), .rx_synced_out(rx_synced_in), .rem_ok_out(rem_rcvr_ok_in),
        .loc_ok_out(loc_rcvr_ok_in), .lock_out(descrambler_lock_flag_in), .pol_inv_out(polarity_inverted_in));
    initial forever #4 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        reg_write_in = 1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_sys_in);
        reg_write_in = 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input string what);
        @(negedge clk_sys_in);
        reg_read_in = 1;
        reg_addr_in = a;
        exp_q.push_back(e);
        name_q.push_back(what);
        @(negedge clk_sys_in);
        reg_read_in = 0;
        @(negedge clk_sys_in);
    endtask
    task automatic rst();
        reset_in = 1;
        n_good = 0;
        n_tmo = 0;
        repeat (4) @(negedge clk_sys_in);
        reset_in = 0;
        repeat (25) @(negedge clk_sys_in); // host waits past the normal-mode timeout
    endtask
    // bound stands in for the host's diagnosis deadline
    task automatic wait_mode(input logic [1:0] m, output int n);
        n = 0;
        while (tx_mode_out !== m && n < 600) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("tx_mode", tx_mode_out, m);
    endtask
    ////////////////////////////////////////////////////////////////
    // answers are matched to the oldest read in flight
    always @(negedge clk_sys_in) begin
        if (reg_rvalid_out === 1'b1) check(name_q.pop_front(), reg_rdata_out, exp_q.pop_front());
    end
    always @(negedge clk_sys_in) n_good += (link_good_event_out === 1'b1);
    always @(negedge clk_sys_in) n_tmo += (training_timeout_event_out === 1'b1);
    initial begin
        #60us;
        n_errors++;
        stop_test();
    end
    initial begin
        int n;
        logic [4:0] u;
        void'($urandom(32'hfc2db520));
        rst();
        u = 5'($urandom_range(15, 0));
        wr(u, 16'($urandom));
        rd(u, 16'h0000, "unmapped");
        rd(5'h11, 16'h0000, "ctl_reset");
        rd(5'h17, 16'h0000, "sta_reset");
        alive = 1;
        repeat (30) @(negedge clk_sys_in);
        check("quiet", tx_mode_out, 2'h0);
        $display("test registers done");
        slow = 1'($urandom);
        wr(5'h11, 16'h8004);
        wait_mode(2'h1, n);
        wait_mode(2'h2, n);
        rd(5'h17, 16'hf400, "sta_master");
        check("good_event", 16'(n_good), 16'h1);
        $display("test master done");
        invert = 1; // settles through the filters after reset, during the normal-mode wait
        rst();
        slow = 0;
        wr(5'h11, 16'h8000);
        wait_mode(2'h1, n);
        wait_mode(2'h2, n);
        check("minwait", 16'(n >= 50), 16'h1);
        check("swap", polarity_swap_out, 1'b1);
        check("data_en", data_enable_out, 1'b1);
        rd(5'h17, 16'hfc00, "sta_slave");
        $display("test slave done");
        rst();
        invert = 0;
        alive = 0;
        wr(5'h11, 16'h8004);
        for (n = 0; n < 400 && n_tmo == 0; n++) @(negedge clk_sys_in);
        check("timeout", 16'(n_tmo), 16'h1);
        alive = 1;
        wait_mode(2'h2, n);
        $display("test timeout done");
        rst();
        normal_mode_in = 0; // normal mode starts again, so the automatic enable must wait
        wr(5'h11, 16'h000c);
        normal_mode_in = 1;
        repeat (15) @(negedge clk_sys_in);
        check("auto_wait", tx_mode_out, 2'h0);
        wait_mode(2'h2, n);
        rd(5'h11, 16'h800c, "ctl_auto");
        $display("test autonomous done");
        stop_test();
    end
endmodule // t1_link_startup_control_tb
